// file: pkg/pcc_params.svh
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// Register byte offsets on the Wishbone bus
`define PCC_OFF_SCTL  8'h00
`define PCC_OFF_HALT1 8'h04
`define PCC_OFF_HALT2 8'h08
`define PCC_OFF_STBY  8'h0C
`define PCC_OFF_STAT  8'h10

// Reset value of every control byte
`define PCC_RST_BYTE  8'h00

// Writable bits of the two module halt registers
`define PCC_HALT1_MASK 8'h7B
`define PCC_HALT2_MASK 8'h93

// Bit positions in the first module halt register
`define PCC_H1_TWI    6
`define PCC_H1_SP1    5
`define PCC_H1_ADC    4
`define PCC_H1_WDT    3
`define PCC_H1_GT1    1
`define PCC_H1_RTC    0

// Bit positions in the second module halt register
`define PCC_H2_SP2    7
`define PCC_H2_GT2    4
`define PCC_H2_GT3    1
`define PCC_H2_PWM    0

// Divider exponents, ratio is two to this power
`define PCC_EXP_DIV1  3'h0
`define PCC_EXP_DIV2  3'h1
`define PCC_EXP_DIV4  3'h2
`define PCC_EXP_DIV8  3'h3
`define PCC_EXP_DIV16 3'h4
`define PCC_EXP_DIV32 3'h5
`define PCC_EXP_DIV64 3'h6

`endif

// file: pkg/pcc_pkg.sv
package pcc_pkg;

  // Operating states of the core
  typedef enum logic [2:0] {
    PCC_ACTIVE    = 3'b000,
    PCC_SLEEP     = 3'b001,
    PCC_SUBACTIVE = 3'b010,
    PCC_SUBSLEEP  = 3'b011,
    PCC_STANDBY   = 3'b100
  } pcc_mode_t;

  // Sleep and clock control byte, bit 7 first
  typedef struct packed {
    logic       sleep_kind_select;
    logic       low_speed_select;
    logic       direct_transfer_select;
    logic [2:0] active_clock_divider_select;
    logic [1:0] sub_clock_divider_select;
  } pcc_sctl_t;

  // Per-module standby outputs
  typedef struct packed {
    logic two_wire_unit_halt;
    logic serial_port_one_halt;
    logic analog_converter_halt;
    logic watchdog_halt;
    logic general_timer_one_halt;
    logic real_time_clock_halt;
    logic serial_port_two_halt;
    logic general_timer_two_halt;
    logic general_timer_three_halt;
    logic pulse_width_unit_halt;
  } pcc_halt_t;

endpackage : pcc_pkg

// file: hdl/pcc_clk_div.sv
`timescale 1ns/1ps
`include "pcc_params.svh"

// Power-of-two enable divider, one output pulse per 2**exp input ticks
module pcc_clk_div
  import pcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       clr_i,
  input  wire logic [2:0] exp_i,
  output logic            en_o
);

  logic [5:0] cnt_reg;
  logic [5:0] limit;

  // Terminal count for the selected ratio
  assign limit = 6'((7'h01 << exp_i) - 7'h01);

  // Count ticks, restart on a new ratio
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_reg <= 6'h00;
    end else if (tick_i) begin
      cnt_reg <= (cnt_reg >= limit) ? 6'h00 : cnt_reg + 6'h01;
    end
  end

  // One-cycle enable at terminal count
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      en_o <= 1'b0;
    end else begin
      en_o <= tick_i && (cnt_reg >= limit);
    end
  end

endmodule : pcc_clk_div

// file: hdl/pcc_top.sv
`timescale 1ns/1ps
`include "pcc_params.svh"

// How it works
// - Active divider 0XX passes oscillator clock, 100..111 divide by 8,16,32,64.
// - Sub divider 00 divides watch clock by 8, 01 by 4, 1X by 2.
// - Active divider written value applies only when sleep is executed.
// - Sub divider written value applies only when sleep is executed.
// - Kind, low speed, direct transfer and standby bits pick the sleep target.
// - Sleep halts the program; an interrupt resumes program execution.
// - Direct transfer with kind 0 and low speed 0 goes straight to active.
// - Direct transfer with low speed 1 goes straight to subactive.
// - First halt bit 6 puts the two-wire unit in standby.
// - First halt bit 5 puts serial port one in standby.
// - First halt bit 4 puts the analog converter in standby.
// - First halt bit 3 puts the watchdog in standby unless wdt_int_osc_i is high.
// - First halt bit 1 puts general timer one in standby.
// - First halt bit 0 puts the real-time clock in standby.
// - Second halt bit 7 puts serial port two in standby.
// - Second halt bit 4 puts general timer two in standby.
// - Second halt bit 1 puts general timer three in standby.
// - Second halt bit 0 puts the pulse-width unit in standby.
// - First halt bits 7 and 2 always read zero.
// - Second halt bits 6, 5, 3 and 2 always read zero.
module pcc_top
  import pcc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sleep_exec_i,
  input  wire logic        wake_irq_i,
  input  wire logic        wdt_int_osc_i,
  input  wire logic        watch_clk_i,
  output pcc_mode_t        mode_o,
  output logic             cpu_halt_o,
  output logic             hs_clk_en_o,
  output logic             ls_clk_en_o,
  output pcc_halt_t        module_halt_o
);

  pcc_sctl_t  sctl_reg;
  logic [7:0] halt1_reg;
  logic [7:0] halt2_reg;
  logic       stby_reg;
  logic [2:0] act_sel_reg;
  logic [1:0] sub_sel_reg;
  logic [2:0] act_exp;
  logic [2:0] sub_exp;
  pcc_mode_t  mode_next;
  logic       bus_req;
  logic       wr_lo;
  logic       sleep_take;
  logic       hs_run;
  logic [2:0] wsync_reg;
  logic       watch_rise;
  logic       watch_lvl_reg;
  logic [31:0] rd_next;

  // Bus request accepted in the cycle before ack
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo   = bus_req && wb_we_i && wb_sel_i[0];

  // Sleep only counts while the program runs
  assign sleep_take = sleep_exec_i && !cpu_halt_o;

  // Ack one cycle after request, dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Sleep and clock control byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sctl_reg <= pcc_sctl_t'(`PCC_RST_BYTE);
    end else if (wr_lo && wb_adr_i == `PCC_OFF_SCTL) begin
      sctl_reg <= pcc_sctl_t'(wb_dat_i[7:0]);
    end
  end

  // Module halt bytes, reserved bits forced low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt1_reg <= `PCC_RST_BYTE;
      halt2_reg <= `PCC_RST_BYTE;
    end else if (wr_lo && wb_adr_i == `PCC_OFF_HALT1) begin
      halt1_reg <= wb_dat_i[7:0] & `PCC_HALT1_MASK;
    end else if (wr_lo && wb_adr_i == `PCC_OFF_HALT2) begin
      halt2_reg <= wb_dat_i[7:0] & `PCC_HALT2_MASK;
    end
  end

  // Standby select bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stby_reg <= 1'b0;
    end else if (wr_lo && wb_adr_i == `PCC_OFF_STBY) begin
      stby_reg <= wb_dat_i[0];
    end
  end

  // Divider selects take effect only at sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_sel_reg <= 3'h0;
      sub_sel_reg <= 2'h0;
    end else if (sleep_take) begin
      act_sel_reg <= sctl_reg.active_clock_divider_select;
      sub_sel_reg <= sctl_reg.sub_clock_divider_select;
    end
  end

  // Active select to divider exponent
  always_comb begin
    unique case (act_sel_reg)
      3'b100:  act_exp = `PCC_EXP_DIV8;
      3'b101:  act_exp = `PCC_EXP_DIV16;
      3'b110:  act_exp = `PCC_EXP_DIV32;
      3'b111:  act_exp = `PCC_EXP_DIV64;
      default: act_exp = `PCC_EXP_DIV1;
    endcase
  end

  // Sub select to divider exponent
  always_comb begin
    unique case (sub_sel_reg)
      2'b00:   sub_exp = `PCC_EXP_DIV8;
      2'b01:   sub_exp = `PCC_EXP_DIV4;
      default: sub_exp = `PCC_EXP_DIV2;
    endcase
  end

  // Next state on sleep or wake-up
  always_comb begin
    mode_next = mode_o;
    if (sleep_take) begin
      if (sctl_reg.direct_transfer_select && sctl_reg.low_speed_select) begin
        mode_next = PCC_SUBACTIVE;
      end else if (sctl_reg.direct_transfer_select && !sctl_reg.sleep_kind_select) begin
        mode_next = PCC_ACTIVE;
      end else if (stby_reg) begin
        mode_next = PCC_STANDBY;
      end else if (sctl_reg.sleep_kind_select) begin
        mode_next = PCC_SUBSLEEP;
      end else begin
        mode_next = PCC_SLEEP;
      end
    end else if (wake_irq_i && cpu_halt_o) begin
      if (mode_o != PCC_STANDBY && sctl_reg.low_speed_select) begin
        mode_next = PCC_SUBACTIVE;
      end else begin
        mode_next = PCC_ACTIVE;
      end
    end
  end

  // Operating state and program halt flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o     <= PCC_ACTIVE;
      cpu_halt_o <= 1'b0;
    end else begin
      mode_o     <= mode_next;
      cpu_halt_o <= (mode_next == PCC_SLEEP) || (mode_next == PCC_SUBSLEEP)
                    || (mode_next == PCC_STANDBY);
    end
  end

  // Watch clock pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wsync_reg <= 3'h0;
    end else begin
      wsync_reg <= {wsync_reg[1:0], watch_clk_i};
    end
  end

  // Accepted watch level, moves only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watch_lvl_reg <= 1'b0;
    end else if (wsync_reg[1] == wsync_reg[2]) begin
      watch_lvl_reg <= wsync_reg[2];
    end
  end

  // Rising edge counts when both late stages show high over a low level
  assign watch_rise = wsync_reg[1] && wsync_reg[2] && !watch_lvl_reg;

  // High-speed clock runs in active and sleep only
  assign hs_run = (mode_o == PCC_ACTIVE) || (mode_o == PCC_SLEEP);

  // High-speed enable from the oscillator clock
  pcc_clk_div u_hs_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (hs_run),
    .clr_i  (sleep_take),
    .exp_i  (act_exp),
    .en_o   (hs_clk_en_o)
  );

  // Low-speed enable from the watch clock
  pcc_clk_div u_ls_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (watch_rise),
    .clr_i  (sleep_take),
    .exp_i  (sub_exp),
    .en_o   (ls_clk_en_o)
  );

  // Per-module standby outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      module_halt_o <= '0;
    end else begin
      module_halt_o.two_wire_unit_halt       <= halt1_reg[`PCC_H1_TWI];
      module_halt_o.serial_port_one_halt     <= halt1_reg[`PCC_H1_SP1];
      module_halt_o.analog_converter_halt    <= halt1_reg[`PCC_H1_ADC];
      module_halt_o.watchdog_halt            <= halt1_reg[`PCC_H1_WDT]
                                                && !wdt_int_osc_i;
      module_halt_o.general_timer_one_halt   <= halt1_reg[`PCC_H1_GT1];
      module_halt_o.real_time_clock_halt     <= halt1_reg[`PCC_H1_RTC];
      module_halt_o.serial_port_two_halt     <= halt2_reg[`PCC_H2_SP2];
      module_halt_o.general_timer_two_halt   <= halt2_reg[`PCC_H2_GT2];
      module_halt_o.general_timer_three_halt <= halt2_reg[`PCC_H2_GT3];
      module_halt_o.pulse_width_unit_halt    <= halt2_reg[`PCC_H2_PWM];
    end
  end

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (wb_adr_i)
      `PCC_OFF_SCTL:  rd_next[7:0] = sctl_reg;
      `PCC_OFF_HALT1: rd_next[7:0] = halt1_reg;
      `PCC_OFF_HALT2: rd_next[7:0] = halt2_reg;
      `PCC_OFF_STBY:  rd_next[0]   = stby_reg;
      `PCC_OFF_STAT:  rd_next[8:0] = {sub_sel_reg, act_sel_reg, cpu_halt_o, mode_o};
      default:        rd_next      = 32'h0000_0000;
    endcase
  end

  // Read data registered with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_next;
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  act_hold_a: assert property (!sleep_take |=> $stable(act_sel_reg))
    else $error("active divider changed without sleep");

  sub_hold_a: assert property (!sleep_take |=> $stable(sub_sel_reg))
    else $error("sub divider changed without sleep");

  sleep_enter_a: assert property (
    sleep_take && !sctl_reg.direct_transfer_select && !stby_reg
    && !sctl_reg.sleep_kind_select |=> mode_o == PCC_SLEEP && cpu_halt_o)
    else $error("sleep did not halt the program");

  wake_active_a: assert property (
    mode_o == PCC_SLEEP && wake_irq_i && !sctl_reg.low_speed_select
    |=> mode_o == PCC_ACTIVE && !cpu_halt_o)
    else $error("interrupt did not resume from sleep");

  standby_enter_a: assert property (
    sleep_take && stby_reg && !sctl_reg.direct_transfer_select
    |=> mode_o == PCC_STANDBY)
    else $error("standby not entered");

  direct_act_a: assert property (
    sleep_take && sctl_reg.direct_transfer_select && !sctl_reg.sleep_kind_select
    && !sctl_reg.low_speed_select |=> mode_o == PCC_ACTIVE && !cpu_halt_o)
    else $error("direct transfer to active failed");

  direct_sub_a: assert property (
    sleep_take && sctl_reg.direct_transfer_select && sctl_reg.low_speed_select
    |=> mode_o == PCC_SUBACTIVE && !cpu_halt_o)
    else $error("direct transfer to subactive failed");

  wdt_keep_a: assert property (wdt_int_osc_i |=> !module_halt_o.watchdog_halt)
    else $error("watchdog halted on internal oscillator");

  twi_map_a: assert property (
    ##1 module_halt_o.two_wire_unit_halt == $past(halt1_reg[`PCC_H1_TWI]))
    else $error("two-wire standby mismatch");

  rsv1_read_a: assert property (
    bus_req && !wb_we_i && wb_adr_i == `PCC_OFF_HALT1
    |=> wb_ack_o && wb_dat_o[7] == 1'b0 && wb_dat_o[2] == 1'b0)
    else $error("reserved bits of first halt register not zero");

  rsv2_read_a: assert property (
    bus_req && !wb_we_i && wb_adr_i == `PCC_OFF_HALT2
    |=> wb_ack_o && wb_dat_o[6:5] == 2'h0 && wb_dat_o[3:2] == 2'h0)
    else $error("reserved bits of second halt register not zero");

  rst_clear_a: assert property (disable iff (1'b0)
    rst_i |=> mode_o == PCC_ACTIVE && !cpu_halt_o && module_halt_o == '0
    && sctl_reg == pcc_sctl_t'(`PCC_RST_BYTE) && halt1_reg == `PCC_RST_BYTE
    && halt2_reg == `PCC_RST_BYTE)
    else $error("reset left a control bit set");

  hs_full_a: assert property (
    !rst_i && hs_run && act_exp == `PCC_EXP_DIV1 && !sleep_take |=> hs_clk_en_o)
    else $error("undivided clock enable missed a cycle");

  hs_gap_a: assert property (
    hs_clk_en_o && act_exp != `PCC_EXP_DIV1 |=> !hs_clk_en_o)
    else $error("divided clock enable lasted two cycles");

  ls_gap_a: assert property (ls_clk_en_o |=> !ls_clk_en_o)
    else $error("low-speed enable lasted two cycles");

  mode_hold_a: assert property (
    !sleep_take && !(wake_irq_i && cpu_halt_o) |=> $stable(mode_o))
    else $error("mode changed with no sleep or wake");

  stby_wake_a: assert property (
    mode_o == PCC_STANDBY && wake_irq_i |=> mode_o == PCC_ACTIVE && !cpu_halt_o)
    else $error("wake from standby did not reach active");

  sub_wake_a: assert property (
    cpu_halt_o && mode_o != PCC_STANDBY && wake_irq_i && sctl_reg.low_speed_select
    |=> mode_o == PCC_SUBACTIVE && !cpu_halt_o)
    else $error("wake did not reach subactive");

  sleep_wake_c: cover property (mode_o == PCC_SLEEP ##[1:50] mode_o == PCC_ACTIVE);
  sub_sleep_c:  cover property (mode_o == PCC_SUBSLEEP);
  standby_c:    cover property (mode_o == PCC_STANDBY);
  sub_direct_c: cover property (mode_o == PCC_ACTIVE ##1 mode_o == PCC_SUBACTIVE);
  ls_tick_c:    cover property (ls_clk_en_o);

endmodule : pcc_top

// file: bench/testbench.sv
`timescale 1ns/1ps
`include "pcc_params.svh"

module testbench
  import pcc_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        sleep_exec_i, wake_irq_i, wdt_int_osc_i, watch_clk_i;
  logic        cpu_halt_o, hs_clk_en_o, ls_clk_en_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0]  wc = 2'h0;
  pcc_mode_t   mode_o;
  pcc_halt_t   module_halt_o;
  int          bad_count = 0;
  int          n_tests = 0;
  int          ehs, els;
  logic [7:0]  b;
  logic [4:0]  dv [5] = '{5'h10, 5'h15, 5'h1A, 5'h1F, 5'h0C};
  logic [3:0]  mc [6] = '{4'h0, 4'h8, 4'hC, 4'h1, 4'h6, 4'h2};
  pcc_mode_t   me [6] = '{PCC_SLEEP, PCC_SUBSLEEP, PCC_SUBSLEEP, PCC_STANDBY,
                          PCC_SUBACTIVE, PCC_ACTIVE};
  pcc_mode_t   mw [6] = '{PCC_ACTIVE, PCC_ACTIVE, PCC_SUBACTIVE, PCC_ACTIVE,
                          PCC_SUBACTIVE, PCC_ACTIVE};

  pcc_top u_pcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_exec_i(sleep_exec_i),
    .wake_irq_i(wake_irq_i), .wdt_int_osc_i(wdt_int_osc_i), .watch_clk_i(watch_clk_i),
    .mode_o(mode_o), .cpu_halt_o(cpu_halt_o), .hs_clk_en_o(hs_clk_en_o),
    .ls_clk_en_o(ls_clk_en_o), .module_halt_o(module_halt_o));

  // Clock generation
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Watch clock at a quarter of the main clock
  always @(posedge clk_i) begin
    wc          <= wc + 2'h1;
    watch_clk_i <= wc[1];
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("bus ack", 32'h0, 32'h1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(what, {24'h000000, q}, {24'h000000, e});
  endtask : rd

  // Sleep (irq 0) or wake (irq 1) one-cycle request
  task automatic pulse(input logic irq);
    @(posedge clk_i);
    if (irq) wake_irq_i <= 1'b1;
    else sleep_exec_i <= 1'b1;
    @(posedge clk_i);
    wake_irq_i   <= 1'b0;
    sleep_exec_i <= 1'b0;
    @(posedge clk_i);
  endtask : pulse

  task automatic chk_mode(input pcc_mode_t m, input logic h);
    chk("mode", {29'h0, mode_o}, {29'h0, m});
    chk("halted", {31'h0, cpu_halt_o}, {31'h0, h});
  endtask : chk_mode

  // Count enable pulses over a window
  task automatic win(input int n, input int e_hs, input int e_ls);
    int hs, ls;
    hs = 0;
    ls = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (hs_clk_en_o === 1'b1) hs++;
      if (ls_clk_en_o === 1'b1) ls++;
    end
    chk("hs pulses", hs, e_hs);
    chk("ls pulses", ls, e_ls);
  endtask : win

  function automatic logic [9:0] exp_halt(input logic [7:0] a, input logic [7:0] c,
                                          input logic w);
    return {a[6], a[5], a[4], a[3] & ~w, a[1], a[0], c[7], c[4], c[1], c[0]};
  endfunction : exp_halt

  // Hang guard
  initial begin
    #600000;
    bad_count++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, sleep_exec_i, wake_irq_i, wdt_int_osc_i} = 6'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h1;
    rst_i    = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`PCC_OFF_SCTL, 8'h00, "ctrl reset");
    rd(`PCC_OFF_HALT1, 8'h00, "halt1 reset");
    rd(`PCC_OFF_HALT2, 8'h00, "halt2 reset");
    chk("halt out", module_halt_o, 32'h0);
    chk_mode(PCC_ACTIVE, 1'b0);
    win(256, 256, 8);
    $display("test reset done");
    // Walk each bit of both halt registers
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      wr(`PCC_OFF_HALT1, b);
      rd(`PCC_OFF_HALT1, b & 8'h7B, "halt1 read");
      chk("halt1 out", module_halt_o, exp_halt(b, 8'h00, 1'b0));
    end
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      wr(`PCC_OFF_HALT2, b);
      rd(`PCC_OFF_HALT2, b & 8'h93, "halt2 read");
      chk("halt2 out", module_halt_o, exp_halt(8'h00, b, 1'b0));
    end
    wr(`PCC_OFF_HALT1, 8'hFF);
    @(posedge clk_i);
    wdt_int_osc_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("wdt on osc", module_halt_o, exp_halt(8'hFF, 8'h80, 1'b1));
    wdt_int_osc_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("wdt off osc", module_halt_o, exp_halt(8'hFF, 8'h80, 1'b0));
    wr(`PCC_OFF_HALT1, 8'h00);
    $display("test halt done");
    // Divider selects apply only at sleep
    ehs = 256;
    els = 8;
    for (int i = 0; i < 5; i++) begin
      wr(`PCC_OFF_SCTL, {3'h0, dv[i]});
      rd(`PCC_OFF_SCTL, {3'h0, dv[i]}, "ctrl read");
      win(256, ehs, els);
      pulse(1'b0);
      chk_mode(PCC_SLEEP, 1'b1);
      ehs = dv[i][4] ? (256 >> (3 + dv[i][3:2])) : 256;
      els = dv[i][1] ? 32 : (dv[i][0] ? 16 : 8);
      win(256, ehs, els);
      pulse(1'b1);
      chk_mode(PCC_ACTIVE, 1'b0);
    end
    $display("test divider done");
    // Sleep targets and wake targets
    for (int i = 0; i < 6; i++) begin
      wr(`PCC_OFF_STBY, {7'h00, mc[i][0]});
      rd(`PCC_OFF_STBY, {7'h00, mc[i][0]}, "stby read");
      wr(`PCC_OFF_SCTL, {mc[i][3:1], 5'h00});
      pulse(1'b0);
      chk_mode(me[i], (i < 4));
      pulse(1'b1);
      chk_mode(mw[i], 1'b0);
    end
    $display("test modes done");
    rd(8'h40, 8'h00, "unmapped read");
    $display("test unmapped done");
    // Reset in mid-run clears every control bit again
    wr(`PCC_OFF_HALT1, 8'hFF);
    wr(`PCC_OFF_HALT2, 8'hFF);
    wr(`PCC_OFF_SCTL, 8'hFF);
    chk("halt set", module_halt_o, exp_halt(8'hFF, 8'hFF, 1'b0));
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("halt out", module_halt_o, 32'h0);
    rd(`PCC_OFF_SCTL, 8'h00, "ctrl reset");
    rd(`PCC_OFF_HALT1, 8'h00, "halt1 reset");
    rd(`PCC_OFF_HALT2, 8'h00, "halt2 reset");
    chk_mode(PCC_ACTIVE, 1'b0);
    win(256, 256, 8);
    $display("test mid reset done");
    end_sim();
  end
endmodule : testbench
